// >>> logic/ttdr_top.sv
// Purpose: test data registers, chain select and scan cells
// Assumes: tap state code comes from a controller on the test clock
// Notes:   core step crosses to the system clock by a toggle
`timescale 1ns/1ps
`include "ttdr_params.svh"

// Behaviour
// - identification register is the serial path under IDCODE
// - identification register loads fixed code at capture-DR
// - four-bit instruction register is the path in shift-IR
// - capture-IR loads 0001; update-IR makes it current
// - test reset makes IDCODE the current instruction
// - chain select register is the path under SCAN_N in shift-DR
// - chain select loads 1000 at capture-DR, shifts LSB first
// - update-DR picks active chain; later instructions use it
// - active chain changes only by SCAN_N or reset; reset gives 3
// - active chain number is always driven on a 4-bit output
// - instruction, tap state code and scan phases are exported
// - chain 3 and unassigned chains route via external chain pins
// - chain numbers decode as macrocell, debug, reserved, external
// - chain 0 has 105 cells, chain 1 has 33 cells
// - input cells capture system input, output cells core output
// - cell mux drives normal signal or serial register by mode
// - modes SYSTEM, INTEST and EXTEST
// - no update stage except data bus, other outputs follow the shifting
// - INTEST chain 0 clocks core once in run-test/idle
// - EXTEST chain 0 drives data bus cells at update-DR
// - chain 1 debug uses the INTEST procedure; EXTEST drives no outputs
// - unassigned instruction codes act as bypass
module ttdr_top #(
    parameter logic [`TTDR_ID_W-1:0] ID_CODE = 32'h0000_0001 // arbitrary
) (
    // system clock domain
    input  wire logic                     clock,
    input  wire logic                     rstn,
    output logic                          core_step,
    // serial test port
    input  wire logic                     test_shift_clock,
    input  wire logic                     test_reset_n,
    input  wire logic [3:0]               tap_state_in,
    input  wire logic                     test_serial_in,
    output logic                          test_serial_out,
    // exports for external chains
    output logic [3:0]                    active_chain_number,
    output logic [3:0]                    current_instruction_bits,
    output logic [3:0]                    tap_state_code,
    output logic                          scan_phase_one,
    output logic                          scan_phase_two,
    output logic                          external_chain_serial_out,
    input  wire logic                     external_chain_serial_return,
    // chain 0 cells
    input  wire logic [`TTDR_CH0_IN-1:0]  sys_to_core,
    output logic      [`TTDR_CH0_IN-1:0]  core_in,
    input  wire logic [`TTDR_CH0_OUT-1:0] core_out,
    output logic      [`TTDR_CH0_OUT-1:0] sys_out,
    // chain 1 cells, data bus and breakpoint
    input  wire logic [`TTDR_CH1_LEN-1:0] sys_dbg_in,
    output logic      [`TTDR_CH1_LEN-1:0] core_dbg_in
);

    // -----------------------------------------------------------------
    // decode functions
    // -----------------------------------------------------------------
    function automatic ttdr_pkg::ttdr_mode_t mode_of(
        input logic [3:0] ins);
        unique case (ins)
            `TTDR_INS_INTEST:  mode_of = ttdr_pkg::TTDR_INTEST;
            `TTDR_INS_EXTEST,
            `TTDR_INS_CLAMP,
            `TTDR_INS_CLAMPZ:  mode_of = ttdr_pkg::TTDR_EXTEST;
            default:           mode_of = ttdr_pkg::TTDR_SYSTEM;
        endcase
    endfunction

    // chain 3 and every unallocated number go to the external pins
    function automatic logic is_external(input logic [3:0] ch);
        unique case (ch)
            `TTDR_CH_TEST,
            `TTDR_CH_DEBUG,
            `TTDR_CH_DBGPROG,
            `TTDR_CH_RES4,
            `TTDR_CH_RES8,
            `TTDR_CH_SYSCP: is_external = 1'b0;
            default:        is_external = 1'b1;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // link domain state
    // -----------------------------------------------------------------
    ttdr_pkg::ttdr_link_t l_reg;
    ttdr_pkg::ttdr_link_t l_next;
    ttdr_pkg::ttdr_tap_t  st;
    ttdr_pkg::ttdr_mode_t mode;
    logic                 scan_sel;
    logic                 on_ch0;
    logic                 on_ch1;
    logic                 on_ext;
    logic                 path_csel;
    logic                 path_id;
    logic                 path_byp;

    assign st   = ttdr_pkg::ttdr_tap_t'(tap_state_in);
    assign mode = mode_of(l_reg.instr);

    always_comb begin
        scan_sel  = (mode != ttdr_pkg::TTDR_SYSTEM) &&
                    (l_reg.instr != `TTDR_INS_CLAMP) &&
                    (l_reg.instr != `TTDR_INS_CLAMPZ);
        on_ch0    = scan_sel && (l_reg.chain == `TTDR_CH_TEST);
        on_ch1    = scan_sel && (l_reg.chain == `TTDR_CH_DEBUG);
        on_ext    = scan_sel && is_external(l_reg.chain);
        path_csel = (l_reg.instr == `TTDR_INS_SCAN_N);
        path_id   = (l_reg.instr == `TTDR_INS_IDCODE);
        // reserved chains fall back to bypass: their layouts are absent
        path_byp  = !path_csel && !path_id && !on_ch0 && !on_ch1 &&
                    !on_ext;
    end

    always_comb begin
        l_next = l_reg;
        // pin synchronisers for every captured input
        l_next.in_a  = sys_to_core;
        l_next.in_b  = l_reg.in_a;
        l_next.out_a = core_out;
        l_next.out_b = l_reg.out_a;
        l_next.c1_a  = sys_dbg_in;
        l_next.c1_b  = l_reg.c1_a;
        unique case (st)
            ttdr_pkg::TTDR_RESET: begin
                l_next.instr = `TTDR_INS_IDCODE;
            end
            ttdr_pkg::TTDR_CAP_IR: begin
                l_next.ir = `TTDR_IR_CAPTURE;
            end
            ttdr_pkg::TTDR_SHIFT_IR: begin
                l_next.ir = {test_serial_in,
                             l_reg.ir[`TTDR_IR_LEN-1:1]};
            end
            ttdr_pkg::TTDR_UPD_IR: begin
                l_next.instr = l_reg.ir;
            end
            ttdr_pkg::TTDR_CAP_DR: begin
                l_next.byp = 1'b0;
                if (path_id) begin
                    l_next.idr = ID_CODE;
                end
                if (path_csel) begin
                    l_next.csel = `TTDR_CSEL_CAPTURE;
                end
                if (on_ch0) begin
                    l_next.c0 = {l_reg.in_b, l_reg.out_b};
                end
                if (on_ch1) begin
                    l_next.c1 = l_reg.c1_b;
                end
            end
            ttdr_pkg::TTDR_SHIFT_DR: begin
                if (path_id) begin
                    l_next.idr = {test_serial_in,
                                  l_reg.idr[`TTDR_ID_W-1:1]};
                end
                if (path_csel) begin
                    l_next.csel = {test_serial_in,
                                   l_reg.csel[3:1]};
                end
                if (on_ch0) begin
                    l_next.c0 = {test_serial_in,
                                 l_reg.c0[`TTDR_CH0_LEN-1:1]};
                end
                if (on_ch1) begin
                    l_next.c1 = {test_serial_in,
                                 l_reg.c1[`TTDR_CH1_LEN-1:1]};
                end
                if (path_byp) begin
                    l_next.byp = test_serial_in;
                end
            end
            ttdr_pkg::TTDR_UPD_DR: begin
                if (path_csel) begin
                    l_next.chain = l_reg.csel;
                end
                if (on_ch0 && mode == ttdr_pkg::TTDR_EXTEST) begin
                    l_next.dbus = l_reg.c0[`TTDR_DBUS_W-1:0];
                end
            end
            ttdr_pkg::TTDR_IDLE: begin
                // one step per visit; the host leaves after one cycle
                if ((on_ch0 || on_ch1) &&
                    mode == ttdr_pkg::TTDR_INTEST) begin
                    l_next.step_tgl = !l_reg.step_tgl;
                end
            end
            default: begin
            end
        endcase
    end

    // chain stays 3 until a SCAN_N update, pin reset only
    always_ff @(posedge test_shift_clock or negedge test_reset_n) begin
        if (!test_reset_n) begin
            l_reg       <= '0;
            l_reg.instr <= `TTDR_INS_IDCODE;
            l_reg.chain <= `TTDR_CHAIN_RESET;
            l_reg.csel  <= `TTDR_CSEL_CAPTURE;
            l_reg.ir    <= `TTDR_IR_CAPTURE;
        end else begin
            l_reg <= l_next;
        end
    end

    // -----------------------------------------------------------------
    // serial output and exports
    // -----------------------------------------------------------------
    always_comb begin
        if (st == ttdr_pkg::TTDR_SHIFT_IR) begin
            test_serial_out = l_reg.ir[0];
        end else if (path_id) begin
            test_serial_out = l_reg.idr[0];
        end else if (path_csel) begin
            test_serial_out = l_reg.csel[0];
        end else if (on_ch0) begin
            test_serial_out = l_reg.c0[0];
        end else if (on_ch1) begin
            test_serial_out = l_reg.c1[0];
        end else if (on_ext) begin
            test_serial_out = external_chain_serial_return;
        end else begin
            test_serial_out = l_reg.byp;
        end
    end

    // external chains see the raw stream; a mux outside picks returns
    assign external_chain_serial_out = test_serial_in;
    assign active_chain_number       = l_reg.chain;
    assign current_instruction_bits  = l_reg.instr;
    assign tap_state_code            = tap_state_in;
    assign scan_phase_one            = test_shift_clock;
    assign scan_phase_two            = !test_shift_clock;

    // -----------------------------------------------------------------
    // scan cell multiplexers
    // -----------------------------------------------------------------
    // no update stage: outputs ripple with every shift, except data bus
    always_comb begin
        core_in     = sys_to_core;
        sys_out     = core_out;
        core_dbg_in = sys_dbg_in;
        if (on_ch0 && mode == ttdr_pkg::TTDR_INTEST) begin
            core_in = l_reg.c0[`TTDR_CH0_LEN-1:`TTDR_CH0_OUT];
        end
        if (on_ch1 && mode == ttdr_pkg::TTDR_INTEST) begin
            core_dbg_in = l_reg.c1;
        end
        if (on_ch0 && mode == ttdr_pkg::TTDR_EXTEST) begin
            sys_out = {l_reg.c0[`TTDR_CH0_OUT-1:`TTDR_DBUS_W],
                       l_reg.dbus};
        end
        if (mode == ttdr_pkg::TTDR_EXTEST && !scan_sel &&
            l_reg.chain == `TTDR_CH_TEST) begin
            sys_out = {l_reg.c0[`TTDR_CH0_OUT-1:`TTDR_DBUS_W],
                       l_reg.dbus};
        end
    end

    // -----------------------------------------------------------------
    // core step crossing into the system clock
    // -----------------------------------------------------------------
    ttdr_pkg::ttdr_sys_t s_reg;
    ttdr_pkg::ttdr_sys_t s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.s1   = l_reg.step_tgl;
        s_next.s2   = s_reg.s1;
        s_next.s3   = s_reg.s2;
        s_next.step = s_reg.s2 ^ s_reg.s3;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign core_step = s_reg.step;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    chk_id_capture: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        (st == ttdr_pkg::TTDR_CAP_DR && path_id) |=> l_reg.idr == ID_CODE)
        else $error("id register missed its code");

    chk_id_path: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        (st == ttdr_pkg::TTDR_SHIFT_DR && path_id)
        |-> test_serial_out == l_reg.idr[0])
        else $error("id register not on serial path");

    chk_ir_path: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        st == ttdr_pkg::TTDR_SHIFT_IR |-> test_serial_out == l_reg.ir[0])
        else $error("instruction register not on serial path");

    chk_ir_capture: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        st == ttdr_pkg::TTDR_CAP_IR |=> l_reg.ir == 4'h1)
        else $error("capture-IR value wrong");

    chk_ir_update: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        st == ttdr_pkg::TTDR_UPD_IR |=> l_reg.instr == $past(l_reg.ir))
        else $error("update-IR did not load instruction");

    chk_tlr_idcode: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        st == ttdr_pkg::TTDR_RESET |=> l_reg.instr == 4'hE)
        else $error("reset state did not select id code");

    chk_csel_capture: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        (st == ttdr_pkg::TTDR_CAP_DR && path_csel)
        ##1 (st == ttdr_pkg::TTDR_SHIFT_DR) |-> test_serial_out == 1'b0)
        else $error("chain select capture value wrong");

    chk_chain_update: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        (st == ttdr_pkg::TTDR_UPD_DR && path_csel)
        |=> active_chain_number == $past(l_reg.csel))
        else $error("active chain not updated");

    chk_chain_hold: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        !(st == ttdr_pkg::TTDR_UPD_DR && path_csel)
        |=> $stable(active_chain_number))
        else $error("active chain changed without update");

    chk_ext_route: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        (st == ttdr_pkg::TTDR_SHIFT_DR && on_ext && !path_id)
        |-> test_serial_out == external_chain_serial_return)
        else $error("external chain return not routed");

    chk_step_idle: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        (st == ttdr_pkg::TTDR_IDLE && on_ch0 &&
         mode == ttdr_pkg::TTDR_INTEST)
        |=> l_reg.step_tgl != $past(l_reg.step_tgl))
        else $error("core not stepped in run-test/idle");

    chk_dbus_update: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        (st == ttdr_pkg::TTDR_UPD_DR && on_ch0 &&
         mode == ttdr_pkg::TTDR_EXTEST)
        |=> sys_out[31:0] == $past(l_reg.c0[31:0]))
        else $error("data bus cells not driven at update-DR");

    chk_bypass_delay: assert property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        (st == ttdr_pkg::TTDR_SHIFT_DR && path_byp)
        ##1 (st == ttdr_pkg::TTDR_SHIFT_DR && path_byp)
        |-> test_serial_out == $past(test_serial_in))
        else $error("bypass delay is not one clock");

    chk_step_pulse: assert property (@(posedge clock)
        disable iff (!rstn)
        core_step |=> !core_step)
        else $error("core step longer than one cycle");

    cov_scan_n: cover property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        st == ttdr_pkg::TTDR_UPD_DR && path_csel);

    cov_intest_step: cover property (@(posedge clock)
        disable iff (!rstn)
        core_step);

    cov_extest: cover property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        st == ttdr_pkg::TTDR_UPD_DR && on_ch0 &&
        mode == ttdr_pkg::TTDR_EXTEST);

    cov_external: cover property (@(posedge test_shift_clock)
        disable iff (!test_reset_n)
        st == ttdr_pkg::TTDR_SHIFT_DR && on_ext);

endmodule

// >>> common/ttdr_params.svh
// Purpose: constants of the test data register set
// Assumes: included by the package and the top module
// Notes:   codes, lengths and capture values
`ifndef TTDR_PARAMS_SVH
`define TTDR_PARAMS_SVH
// -----------------------------------------------------------------
// instruction register
// -----------------------------------------------------------------
`define TTDR_IR_LEN       4
`define TTDR_IR_CAPTURE   4'h1
`define TTDR_INS_EXTEST   4'h0
`define TTDR_INS_SCAN_N   4'h2
`define TTDR_INS_SAMPLE   4'h3
`define TTDR_INS_RESTART  4'h4
`define TTDR_INS_CLAMP    4'h5
`define TTDR_INS_HIGHZ    4'h7
`define TTDR_INS_CLAMPZ   4'h9
`define TTDR_INS_INTEST   4'hC
`define TTDR_INS_IDCODE   4'hE
`define TTDR_INS_BYPASS   4'hF
// -----------------------------------------------------------------
// chain select register and chain numbers
// -----------------------------------------------------------------
`define TTDR_CSEL_CAPTURE 4'h8
`define TTDR_CHAIN_RESET  4'h3
`define TTDR_CH_TEST      4'h0
`define TTDR_CH_DEBUG     4'h1
`define TTDR_CH_DBGPROG   4'h2
`define TTDR_CH_BSCAN     4'h3
`define TTDR_CH_RES4      4'h4
`define TTDR_CH_RES8      4'h8
`define TTDR_CH_SYSCP     4'hF
// -----------------------------------------------------------------
// lengths
// -----------------------------------------------------------------
`define TTDR_ID_W         32
`define TTDR_CH0_LEN      105
`define TTDR_CH0_IN       40
`define TTDR_CH0_OUT      65
`define TTDR_CH1_LEN      33
`define TTDR_DBUS_W       32
// -----------------------------------------------------------------
// tap state codes
// -----------------------------------------------------------------
`define TTDR_ST_EXIT2_DR  4'h0
`define TTDR_ST_EXIT1_DR  4'h1
`define TTDR_ST_SHIFT_DR  4'h2
`define TTDR_ST_PAUSE_DR  4'h3
`define TTDR_ST_SEL_IR    4'h4
`define TTDR_ST_UPD_DR    4'h5
`define TTDR_ST_CAP_DR    4'h6
`define TTDR_ST_SEL_DR    4'h7
`define TTDR_ST_EXIT2_IR  4'h8
`define TTDR_ST_EXIT1_IR  4'h9
`define TTDR_ST_SHIFT_IR  4'hA
`define TTDR_ST_PAUSE_IR  4'hB
`define TTDR_ST_IDLE      4'hC
`define TTDR_ST_UPD_IR    4'hD
`define TTDR_ST_CAP_IR    4'hE
`define TTDR_ST_RESET     4'hF
// -----------------------------------------------------------------
// scan cell modes
// -----------------------------------------------------------------
`define TTDR_MODE_SYSTEM  3'h1
`define TTDR_MODE_INTEST  3'h2
`define TTDR_MODE_EXTEST  3'h4
`endif

// >>> common/ttdr_pkg.sv
// Purpose: types of the test data register set
// Assumes: ttdr_params.svh on the include path
// Notes:   all state travels as packed structs
`include "ttdr_params.svh"
package ttdr_pkg;
    typedef enum logic [3:0] {
        TTDR_EXIT2_DR = `TTDR_ST_EXIT2_DR,
        TTDR_EXIT1_DR = `TTDR_ST_EXIT1_DR,
        TTDR_SHIFT_DR = `TTDR_ST_SHIFT_DR,
        TTDR_PAUSE_DR = `TTDR_ST_PAUSE_DR,
        TTDR_SEL_IR   = `TTDR_ST_SEL_IR,
        TTDR_UPD_DR   = `TTDR_ST_UPD_DR,
        TTDR_CAP_DR   = `TTDR_ST_CAP_DR,
        TTDR_SEL_DR   = `TTDR_ST_SEL_DR,
        TTDR_EXIT2_IR = `TTDR_ST_EXIT2_IR,
        TTDR_EXIT1_IR = `TTDR_ST_EXIT1_IR,
        TTDR_SHIFT_IR = `TTDR_ST_SHIFT_IR,
        TTDR_PAUSE_IR = `TTDR_ST_PAUSE_IR,
        TTDR_IDLE     = `TTDR_ST_IDLE,
        TTDR_UPD_IR   = `TTDR_ST_UPD_IR,
        TTDR_CAP_IR   = `TTDR_ST_CAP_IR,
        TTDR_RESET    = `TTDR_ST_RESET
    } ttdr_tap_t;

    typedef enum logic [2:0] {
        TTDR_SYSTEM = `TTDR_MODE_SYSTEM,
        TTDR_INTEST = `TTDR_MODE_INTEST,
        TTDR_EXTEST = `TTDR_MODE_EXTEST
    } ttdr_mode_t;

    typedef struct packed {
        logic [`TTDR_IR_LEN-1:0]  ir;
        logic [`TTDR_IR_LEN-1:0]  instr;
        logic [3:0]               csel;
        logic [3:0]               chain;
        logic [`TTDR_ID_W-1:0]    idr;
        logic                     byp;
        logic [`TTDR_CH0_LEN-1:0] c0;
        logic [`TTDR_CH1_LEN-1:0] c1;
        logic [`TTDR_DBUS_W-1:0]  dbus;
        logic [`TTDR_CH0_IN-1:0]  in_a;
        logic [`TTDR_CH0_IN-1:0]  in_b;
        logic [`TTDR_CH0_OUT-1:0] out_a;
        logic [`TTDR_CH0_OUT-1:0] out_b;
        logic [`TTDR_CH1_LEN-1:0] c1_a;
        logic [`TTDR_CH1_LEN-1:0] c1_b;
        logic                     step_tgl;
    } ttdr_link_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic step;
    } ttdr_sys_t;
endpackage

// >>> bench/ttdr_ext_chain.sv
// Purpose: model of one external scan chain
// Assumes: it answers as chain 3, eight cells
// Notes:   the return is inverted while deselected
`timescale 1ns/1ps
// ----
// external chain
// ----
module ttdr_ext_chain (
    // scan side
    input  wire logic       scan_phase_one,
    input  wire logic [3:0] tap_state_code,
    input  wire logic [3:0] active_chain_number,
    input  wire logic       external_chain_serial_out,
    output logic            external_chain_serial_return
);
    logic [7:0] chain_reg = 8'h00;
    logic       sel;
    assign sel = active_chain_number == 4'h3;
    always @(posedge scan_phase_one) begin
        if (sel && tap_state_code == 4'h2) begin
            chain_reg <= {external_chain_serial_out, chain_reg[7:1]};
        end
    end
    // a stale bit must never pass for data
    assign external_chain_serial_return = sel ? chain_reg[0] : ~chain_reg[0];
endmodule

// >>> bench/tb_ttdr_top.sv
// Purpose: self-checking bench of the test data registers
// Assumes: default identity code, external chain of 8 cells
// Notes:   test clock runs free, so idle is left after one cycle
`timescale 1ns/1ps
module tb_ttdr_top;
    localparam logic [127:0] PAT =
        128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    logic         clock, rstn, test_shift_clock, test_reset_n, test_serial_in;
    logic         core_step, test_serial_out, scan_phase_one, scan_phase_two;
    logic         external_chain_serial_out, external_chain_serial_return;
    logic [3:0]   tap_state_in, active_chain_number, tap_state_code;
    logic [3:0]   current_instruction_bits;
    logic [39:0]  sys_to_core, core_in;
    logic [64:0]  core_out, sys_out;
    logic [32:0]  sys_dbg_in, core_dbg_in;
    logic [127:0] q;
    int           bad_count = 0, samples_checked = 0, steps = 0, n0;

    ttdr_top uut (.clock, .rstn, .core_step, .test_shift_clock, .test_reset_n,
        .tap_state_in, .test_serial_in, .test_serial_out, .active_chain_number,
        .current_instruction_bits, .tap_state_code, .scan_phase_one,
        .scan_phase_two, .external_chain_serial_out,
        .external_chain_serial_return, .sys_to_core, .core_in, .core_out,
        .sys_out, .sys_dbg_in, .core_dbg_in);
    ttdr_ext_chain ext (.scan_phase_one, .tap_state_code, .active_chain_number,
        .external_chain_serial_out, .external_chain_serial_return);

    // ----
    // clocks and helpers
    // ----
    always #10 clock = ~clock;
    initial begin
        #3;
        forever #80 test_shift_clock = ~test_shift_clock;
    end
    always @(posedge clock) begin
        if (core_step === 1'b1) begin
            steps++;
        end
    end
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic go(input logic [3:0] st, input logic d);
        @(posedge test_shift_clock);
        tap_state_in <= st;
        test_serial_in <= d;
        #1;
    endtask
    // ir states other than select-IR are the dr codes with bit 3 set
    task automatic scan(input logic ir, input int n, input logic [127:0] d);
        logic [3:0] o;
        o = {ir, 3'h0};
        q = '0;
        if (ir) begin
            go(ttdr_pkg::TTDR_SEL_IR, 1'b0);
        end
        go(ttdr_pkg::TTDR_CAP_DR | o, 1'b0);
        for (int i = 0; i < n; i++) begin
            go(ttdr_pkg::TTDR_SHIFT_DR | o, d[i]);
            q[i] = test_serial_out;
        end
        go(ttdr_pkg::TTDR_EXIT1_DR | o, 1'b0);
        go(ttdr_pkg::TTDR_UPD_DR | o, 1'b0);
        go(ttdr_pkg::TTDR_IDLE, 1'b0); // one cycle only
        go(ttdr_pkg::TTDR_SEL_DR, 1'b0);
    endtask
    task automatic ir_load(input logic [3:0] code);
        scan(1'b1, 4, {124'h0, code});
        check(q[3:0] === 4'h1, "ir capture");
        check(current_instruction_bits === code, "ir");
        repeat (10) @(posedge clock);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_reset_id();
        check(current_instruction_bits === 4'hE, "instr");
        check(active_chain_number === 4'h3, "chain");
        check(core_in === sys_to_core, "sys in");
        check(sys_out === core_out, "sys out");
        check(core_dbg_in === sys_dbg_in, "sys dbg");
        check(tap_state_code === tap_state_in, "state");
        check(scan_phase_one === test_shift_clock, "ph1");
        check(scan_phase_two === !test_shift_clock, "ph2");
        scan(1'b0, 32, 128'h0);
        check(q[31:0] === 32'h0000_0001, "id");
        $display("reset_id done");
    endtask
    task automatic t_select(input logic [3:0] ch);
        ir_load(4'h2);
        scan(1'b0, 4, {124'h0, ch});
        check(q[3:0] === 4'h8, "sel cap");
        check(active_chain_number === ch, "sel");
        $display("select done");
    endtask
    task automatic t_intest();
        ir_load(4'hC);
        check(active_chain_number === 4'h0, "kept");
        n0 = steps;
        scan(1'b0, 105, PAT);
        repeat (10) @(posedge clock);
        check(q[104:0] === {sys_to_core, core_out}, "cap");
        check(core_in === PAT[104:65], "core in");
        check(steps === n0 + 1, "step");
        $display("intest done");
    endtask
    task automatic t_extest();
        ir_load(4'h0);
        n0 = steps;
        scan(1'b0, 105, ~PAT);
        repeat (10) @(posedge clock);
        check(q[104:65] === sys_to_core, "ext cap");
        check(sys_out[31:0] === ~PAT[31:0], "bus");
        check(sys_out[64:32] === ~PAT[64:32], "ripple");
        check(steps === n0, "no step");
        $display("extest done");
    endtask
    task automatic t_debug();
        t_select(4'h1);
        ir_load(4'hC);
        n0 = steps;
        scan(1'b0, 33, PAT);
        repeat (10) @(posedge clock);
        check(q[32:0] === sys_dbg_in, "dbg cap");
        check(core_dbg_in === PAT[32:0], "dbg in");
        check(steps === n0 + 1, "dbg step");
        $display("debug done");
    endtask
    task automatic t_external();
        t_select(4'h3);
        ir_load(4'hC);
        scan(1'b0, 16, 128'hC35A);
        check(q[15:8] === 8'h5A, "external");
        ir_load(4'h6);
        scan(1'b0, 2, 128'h3);
        check(q[1:0] === 2'b10, "bypass");
        $display("external done");
    endtask

    initial begin
        clock = 1'b0;
        test_shift_clock = 1'b0;
        rstn = 1'b0;
        test_reset_n = 1'b0;
        test_serial_in = 1'b0;
        tap_state_in = ttdr_pkg::TTDR_RESET;
        sys_to_core = 40'hA5_C3E1_0F96;
        core_out = 65'h1_3579_BDF0_2468_ACE1;
        sys_dbg_in = 33'h1_5A5A_A5A5;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        test_reset_n <= 1'b1;
        go(ttdr_pkg::TTDR_IDLE, 1'b0);
        go(ttdr_pkg::TTDR_SEL_DR, 1'b0);
        t_reset_id();
        t_select(4'h0);
        t_intest();
        t_extest();
        t_debug();
        t_external();
        final_report();
    end
    initial begin
        #1000000;
        bad_count++;
        final_report();
    end
endmodule
